// ===== logic/vmexd_pkg.sv
// Constants for the guest exit decision block: register map, control bit
// positions, capability reset values and the AXI4-Lite response codes.
package vmexd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_ASYNC_CTL  = 8'h00;
  localparam logic [7:0] ADDR_SYNC_CTL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_TSO_LO     = 8'h0C;
  localparam logic [7:0] ADDR_TSO_HI     = 8'h10;
  localparam logic [7:0] ADDR_ASYNC_CAP0 = 8'h14;
  localparam logic [7:0] ADDR_ASYNC_CAP1 = 8'h18;
  localparam logic [7:0] ADDR_SYNC_CAP0  = 8'h1C;
  localparam logic [7:0] ADDR_SYNC_CAP1  = 8'h20;
  // Asynchronous vector bits
  localparam int BIT_EXT_INT_EXIT = 0;
  localparam int BIT_NMI_EXIT     = 3;
  // Synchronous vector bits
  localparam int BIT_INT_WINDOW   = 2;
  localparam int BIT_TS_OFFSET    = 3;
  localparam int BIT_HALT_EXIT    = 7;
  localparam int BIT_PGINV_EXIT   = 9;
  localparam int BIT_MONITORED_WAIT_INSTRUCTION_EXIT   = 10;
  localparam int BIT_PMC_EXIT     = 11;
  localparam int BIT_TSREAD_EXIT  = 12;
  localparam int BIT_PRIO_WR_EXIT = 19;
  localparam int BIT_PRIO_RD_EXIT = 20;
  localparam int BIT_TP_SHADOW    = 21;
  localparam int BIT_DBG_EXIT     = 23;
  localparam int BIT_IO_ALL_EXIT  = 24;
  localparam int BIT_IO_BITMAP    = 25;
  localparam int BIT_MR_BITMAP    = 28;
  localparam int BIT_WATCH_EXIT   = 29;
  localparam int BIT_SPIN_EXIT    = 30;
  // Descriptor used for non-maskable interrupts delivered to the guest
  localparam logic [7:0] NMI_VECTOR = 8'h02;
  // Port split between the two I/O bitmaps
  localparam logic [15:0] IO_SPLIT_PORT = 16'h8000;
  // Capability defaults: must-be-one mask (cap0) and may-be-one mask (cap1)
  localparam logic [31:0] ASYNC_CAP0_RST = 32'h0000_0016;
  localparam logic [31:0] ASYNC_CAP1_RST = 32'h0000_001F;
  localparam logic [31:0] SYNC_CAP0_RST  = 32'h0401_E172;
  localparam logic [31:0] SYNC_CAP1_RST  = 32'h77FB_FFFE;
  localparam logic [31:0] CTL_RST        = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Event kinds presented by the core
  typedef enum logic [3:0] {
    VMEXD_EV_NONE   = 4'h0,
    VMEXD_EV_HALT   = 4'h1,
    VMEXD_EV_PGINV  = 4'h2,
    VMEXD_EV_MONITORED_WAIT_INSTRUCTION  = 4'h3,
    VMEXD_EV_PMC    = 4'h4,
    VMEXD_EV_TSREAD = 4'h5,
    VMEXD_EV_PRIOWR = 4'h6,
    VMEXD_EV_PRIORD = 4'h7,
    VMEXD_EV_DBG    = 4'h8,
    VMEXD_EV_IO     = 4'h9,
    VMEXD_EV_MRRD   = 4'hA,
    VMEXD_EV_MRWR   = 4'hB,
    VMEXD_EV_WATCH  = 4'hC,
    VMEXD_EV_SPIN   = 4'hD,
    VMEXD_EV_TSMR   = 4'hE
  } vmexd_ev_t;
endpackage

// ===== logic/vmexd_top.sv
// Guest exit decision unit: programmable control vectors, latched at entry,
// deciding whether guest events leave to the host monitor.
// Assumes core-side inputs are synchronous to clk; software uses AXI4-Lite.
//
// What this block does
// (RULE1) External interrupt exits when async bit 0 set
// (RULE2) Exit mode ignores guest interrupt-enable flag
// (RULE3) Async bit 3 routes NMI to exit
// (RULE4) Software honours fixed bits; bad entry fails
// (RULE5) Sync bit 2 exits on open interrupt window
// (RULE6) Sync bit 3 enables time-stamp offsetting
// (RULE7) Sync bit 7 makes halt exit
// (RULE8) Sync bit 9 makes page invalidate exit
// (RULE9) Sync bit 10 makes monitored wait exit
// (RULE10) Sync bit 11 makes counter read exit
// (RULE11) Sync bit 12 makes time-stamp read exit
// (RULE12) Sync bit 19 makes priority writes exit
// (RULE13) Sync bit 20 makes priority reads exit
// (RULE14) Sync bit 21 activates task priority shadow
// (RULE15) Sync bit 23 makes debug moves exit
// (RULE16) Sync bit 24 exits all port instructions
// (RULE17) Sync bit 25 selects I/O bitmap checking
// (RULE18) Sync bit 28 clear makes model accesses exit
// (RULE19) Sync bit 29 makes address-watch arm exit
// (RULE20) Sync bit 30 makes spin hint exit
// (RULE21) Bitmap bit set for any port exits
// (RULE22) Offset result is counter plus signed offset
// (RULE23) Decide only in guest, with entry-latched vectors
`timescale 1ns/1ps
module vmexd_top #(
  parameter logic        HAS_LONG_MODE = 1'b1,
  parameter logic [31:0] ASYNC_CAP0    = vmexd_pkg::ASYNC_CAP0_RST,
  parameter logic [31:0] ASYNC_CAP1    = vmexd_pkg::ASYNC_CAP1_RST,
  parameter logic [31:0] SYNC_CAP0     = vmexd_pkg::SYNC_CAP0_RST,
  parameter logic [31:0] SYNC_CAP1     = vmexd_pkg::SYNC_CAP1_RST
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Entry request from the core
  input  wire logic        entry_req,
  input  wire logic        guest_leave,
  output logic             entry_ok,
  output logic             entry_fail,
  output logic             guest_mode,
  // Guest event from the core
  input  wire logic        ev_valid,
  input  wire logic [3:0]  ev_kind,
  input  wire logic        ext_int,
  input  wire logic        nmi,
  input  wire logic        interrupt_enable_flag,
  input  wire logic        other_int_blocking,
  input  wire logic        io_bitmap_hit,
  input  wire logic        mr_bitmap_hit,
  input  wire logic [63:0] time_stamp_counter,
  // Decision results
  output logic             exit_req,
  output logic [4:0]       exit_cause,
  output logic             deliver_int,
  output logic             deliver_nmi,
  output logic [7:0]       deliver_vector,
  output logic             int_blocked,
  output logic             nmi_interrupt_return_instruction_unblock,
  output logic             task_priority_shadow_en,
  output logic [63:0]      ts_result,
  output logic             ts_result_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers visible to software
  logic [31:0] async_event_exit_controls_q;
  logic [31:0] sync_event_exit_controls_q;
  logic [63:0] ts_offset_q;
  // Copies taken at the last successful entry
  logic [31:0] async_live_q;
  logic [31:0] sync_live_q;
  logic [63:0] ts_offset_live_q;
  logic        guest_q;
  logic        last_fail_q;

  // Fixed-bit check against capability masks
  function automatic logic ctl_ok(input logic [31:0] v, input logic [31:0] must1,
                                  input logic [31:0] may1);
    ctl_ok = ((v & must1) == must1) && ((v & ~may1) == 32'h0000_0000);
  endfunction

  logic async_ok;
  logic sync_ok;
  logic long_ok;
  assign async_ok = ctl_ok(async_event_exit_controls_q, ASYNC_CAP0, ASYNC_CAP1); // RULE4
  assign sync_ok  = ctl_ok(sync_event_exit_controls_q, SYNC_CAP0, SYNC_CAP1);    // RULE4
  // Priority controls only legal with 64-bit support
  assign long_ok = HAS_LONG_MODE ||
    (sync_event_exit_controls_q[vmexd_pkg::BIT_PRIO_WR_EXIT] == 1'b0 && // RULE12
     sync_event_exit_controls_q[vmexd_pkg::BIT_PRIO_RD_EXIT] == 1'b0 && // RULE13
     sync_event_exit_controls_q[vmexd_pkg::BIT_TP_SHADOW] == 1'b0);     // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data held until both present
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Write channel capture and response
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= vmexd_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready;
      s_axi_wready  <= !w_hold_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map(aw_addr_q) ? vmexd_pkg::RESP_OKAY : vmexd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable offsets
  function automatic logic wr_map(input logic [7:0] a);
    wr_map = (a == vmexd_pkg::ADDR_ASYNC_CTL) || (a == vmexd_pkg::ADDR_SYNC_CTL) ||
             (a == vmexd_pkg::ADDR_TSO_LO) || (a == vmexd_pkg::ADDR_TSO_HI);
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Software register storage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      async_event_exit_controls_q <= vmexd_pkg::CTL_RST;
      sync_event_exit_controls_q  <= vmexd_pkg::CTL_RST;
      ts_offset_q                 <= 64'h0000_0000_0000_0000;
    end else if (clk_en && wr_fire) begin
      unique case (aw_addr_q)
        vmexd_pkg::ADDR_ASYNC_CTL:
          async_event_exit_controls_q <= merge(async_event_exit_controls_q, w_data_q, w_strb_q);
        vmexd_pkg::ADDR_SYNC_CTL:
          sync_event_exit_controls_q <= merge(sync_event_exit_controls_q, w_data_q, w_strb_q);
        vmexd_pkg::ADDR_TSO_LO:
          ts_offset_q[31:0] <= merge(ts_offset_q[31:0], w_data_q, w_strb_q);
        vmexd_pkg::ADDR_TSO_HI:
          ts_offset_q[63:32] <= merge(ts_offset_q[63:32], w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // Read channel; one cycle after the address is taken
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= vmexd_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= vmexd_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          vmexd_pkg::ADDR_ASYNC_CTL:  s_axi_rdata <= async_event_exit_controls_q;
          vmexd_pkg::ADDR_SYNC_CTL:   s_axi_rdata <= sync_event_exit_controls_q;
          vmexd_pkg::ADDR_STATUS:     s_axi_rdata <= {29'h0000_0000, last_fail_q,
                                                      sync_live_q[vmexd_pkg::BIT_TP_SHADOW],
                                                      guest_q};
          vmexd_pkg::ADDR_TSO_LO:     s_axi_rdata <= ts_offset_q[31:0];
          vmexd_pkg::ADDR_TSO_HI:     s_axi_rdata <= ts_offset_q[63:32];
          vmexd_pkg::ADDR_ASYNC_CAP0: s_axi_rdata <= ASYNC_CAP0;
          vmexd_pkg::ADDR_ASYNC_CAP1: s_axi_rdata <= ASYNC_CAP1;
          vmexd_pkg::ADDR_SYNC_CAP0:  s_axi_rdata <= SYNC_CAP0;
          vmexd_pkg::ADDR_SYNC_CAP1:  s_axi_rdata <= SYNC_CAP1;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= vmexd_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry: check fixed bits, then latch vectors; leave ends guest mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      guest_q          <= 1'b0;
      last_fail_q      <= 1'b0;
      async_live_q     <= vmexd_pkg::CTL_RST;
      sync_live_q      <= vmexd_pkg::CTL_RST;
      ts_offset_live_q <= 64'h0000_0000_0000_0000;
      entry_ok         <= 1'b0;
      entry_fail       <= 1'b0;
    end else if (clk_en) begin
      entry_ok   <= 1'b0;
      entry_fail <= 1'b0;
      if (entry_req && !guest_q) begin
        if (async_ok && sync_ok && long_ok) begin // RULE4
          guest_q          <= 1'b1;
          last_fail_q      <= 1'b0;
          async_live_q     <= async_event_exit_controls_q; // RULE23
          sync_live_q      <= sync_event_exit_controls_q;  // RULE23
          ts_offset_live_q <= ts_offset_q;
          entry_ok         <= 1'b1;
        end else begin
          last_fail_q <= 1'b1;
          entry_fail  <= 1'b1;
        end
      end else if (guest_q && (guest_leave || exit_req)) begin
        guest_q <= 1'b0; // Any exit returns to host
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exit decision, combinational then registered
  logic       ex_d;
  logic [4:0] cause_d;
  logic       dint_d;
  logic       dnmi_d;
  logic       ts_valid_d;
  logic       io_exit;
  logic       mr_exit;

  // Bitmaps replace the unconditional control when in use
  assign io_exit = sync_live_q[vmexd_pkg::BIT_IO_BITMAP] ? io_bitmap_hit      // RULE17 RULE21
                 : sync_live_q[vmexd_pkg::BIT_IO_ALL_EXIT];                    // RULE16
  assign mr_exit = sync_live_q[vmexd_pkg::BIT_MR_BITMAP] ? mr_bitmap_hit : 1'b1; // RULE18

  // Priority: NMI, external interrupt, window, then instruction
  always_comb begin
    ex_d       = 1'b0;
    cause_d    = 5'h00;
    dint_d     = 1'b0;
    dnmi_d     = 1'b0;
    ts_valid_d = 1'b0;
    if (guest_q && !exit_req) begin // RULE23
      if (nmi) begin
        if (async_live_q[vmexd_pkg::BIT_NMI_EXIT]) begin // RULE3
          ex_d    = 1'b1;
          cause_d = 5'h02;
        end else begin
          dnmi_d = 1'b1;
        end
      end else if (ext_int && async_live_q[vmexd_pkg::BIT_EXT_INT_EXIT] && // RULE1
                   !other_int_blocking) begin // RULE2
        ex_d    = 1'b1;
        cause_d = 5'h01;
      end else if (ext_int && interrupt_enable_flag && !other_int_blocking) begin
        dint_d = 1'b1; // RULE1
      end else if (sync_live_q[vmexd_pkg::BIT_INT_WINDOW] && interrupt_enable_flag &&
                   !other_int_blocking && ev_valid) begin // RULE5
        ex_d    = 1'b1;
        cause_d = 5'h07;
      end else if (ev_valid) begin
        unique case (vmexd_pkg::vmexd_ev_t'(ev_kind))
          vmexd_pkg::VMEXD_EV_HALT:   ex_d = sync_live_q[vmexd_pkg::BIT_HALT_EXIT];   // RULE7
          vmexd_pkg::VMEXD_EV_PGINV:  ex_d = sync_live_q[vmexd_pkg::BIT_PGINV_EXIT];  // RULE8
          vmexd_pkg::VMEXD_EV_MONITORED_WAIT_INSTRUCTION:  ex_d = sync_live_q[vmexd_pkg::BIT_MONITORED_WAIT_INSTRUCTION_EXIT];  // RULE9
          vmexd_pkg::VMEXD_EV_PMC:    ex_d = sync_live_q[vmexd_pkg::BIT_PMC_EXIT];    // RULE10
          vmexd_pkg::VMEXD_EV_TSREAD: ex_d = sync_live_q[vmexd_pkg::BIT_TSREAD_EXIT]; // RULE11
          vmexd_pkg::VMEXD_EV_PRIOWR: ex_d = sync_live_q[vmexd_pkg::BIT_PRIO_WR_EXIT]; // RULE12
          vmexd_pkg::VMEXD_EV_PRIORD: ex_d = sync_live_q[vmexd_pkg::BIT_PRIO_RD_EXIT]; // RULE13
          vmexd_pkg::VMEXD_EV_DBG:    ex_d = sync_live_q[vmexd_pkg::BIT_DBG_EXIT];    // RULE15
          vmexd_pkg::VMEXD_EV_IO:     ex_d = io_exit;
          vmexd_pkg::VMEXD_EV_MRRD:   ex_d = mr_exit;
          vmexd_pkg::VMEXD_EV_MRWR:   ex_d = mr_exit;
          vmexd_pkg::VMEXD_EV_TSMR:   ex_d = mr_exit;
          vmexd_pkg::VMEXD_EV_WATCH:  ex_d = sync_live_q[vmexd_pkg::BIT_WATCH_EXIT];  // RULE19
          vmexd_pkg::VMEXD_EV_SPIN:   ex_d = sync_live_q[vmexd_pkg::BIT_SPIN_EXIT];   // RULE20
          default:                    ex_d = 1'b0;
        endcase
        cause_d = ex_d ? {1'b1, ev_kind} : 5'h00;
        // Time-stamp reads that stay in the guest report a value
        ts_valid_d = !ex_d && ((ev_kind == 4'(vmexd_pkg::VMEXD_EV_TSREAD)) ||
                               (ev_kind == 4'(vmexd_pkg::VMEXD_EV_TSMR)));
      end
    end
  end

  // Registered results, one cycle after the event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exit_req        <= 1'b0;
      exit_cause      <= 5'h00;
      deliver_int     <= 1'b0;
      deliver_nmi     <= 1'b0;
      deliver_vector  <= 8'h00;
      ts_result_valid <= 1'b0;
      ts_result       <= 64'h0000_0000_0000_0000;
    end else if (clk_en) begin
      exit_req        <= ex_d;
      exit_cause      <= cause_d;
      deliver_int     <= dint_d;
      deliver_nmi     <= dnmi_d;
      deliver_vector  <= dnmi_d ? vmexd_pkg::NMI_VECTOR : 8'h00; // RULE3
      ts_result_valid <= ts_valid_d;
      // Signed add equals two's-complement add at full width
      ts_result <= sync_live_q[vmexd_pkg::BIT_TS_OFFSET] ?                 // RULE6
                   64'($signed(time_stamp_counter) + $signed(ts_offset_live_q)) : // RULE22
                   time_stamp_counter;
    end
  end

  // Mode outputs tracking the latched vectors
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_blocked             <= 1'b0;
      nmi_interrupt_return_instruction_unblock        <= 1'b0;
      task_priority_shadow_en <= 1'b0;
      guest_mode              <= 1'b0;
    end else if (clk_en) begin
      guest_mode <= guest_q;
      // Flag only blocks when exit mode is off
      int_blocked <= guest_q && !async_live_q[vmexd_pkg::BIT_EXT_INT_EXIT] && // RULE2
                     (!interrupt_enable_flag || other_int_blocking);
      nmi_interrupt_return_instruction_unblock        <= guest_q && !async_live_q[vmexd_pkg::BIT_NMI_EXIT]; // RULE3
      task_priority_shadow_en <= guest_q && sync_live_q[vmexd_pkg::BIT_TP_SHADOW];  // RULE14
    end
  end

endmodule // vmexd_top

// ===== verif/vmexd_chk.sv
// Checker for the guest exit decision block, watching its top ports only.
// Assumes clk_en stays high, so each decision shows one cycle after its cause.
`timescale 1ns/1ps
module vmexd_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Core inputs
  input wire logic       entry_req,
  input wire logic       ev_valid,
  input wire logic [3:0] ev_kind,
  input wire logic       ext_int,
  input wire logic       nmi,
  input wire logic       interrupt_enable_flag,
  input wire logic       other_int_blocking,
  // Decision outputs
  input wire logic       entry_ok,
  input wire logic       entry_fail,
  input wire logic       guest_mode,
  input wire logic       exit_req,
  input wire logic [4:0] exit_cause,
  input wire logic       deliver_nmi,
  input wire logic [7:0] deliver_vector
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Entry result pulse, then guest state one cycle later
  sequence s_entered;
    entry_ok ##1 guest_mode;
  endsequence
  // Exit with a given cause code
  sequence s_exit_of(logic [4:0] c);
    exit_req && exit_cause == c;
  endsequence
  property p_entry_guest;
    entry_ok |-> s_entered;
  endproperty
  property p_entry_src;
    (entry_ok || entry_fail) |-> $past(entry_req) && !(entry_ok && entry_fail);
  endproperty
  // Single pulse, only while in guest; guest is left within three cycles
  property p_exit_guest;
    exit_req |-> guest_mode ##1 !exit_req;
  endproperty
  property p_exit_leave;
    exit_req |-> ##[1:3] !guest_mode;
  endproperty
  property p_ext;
    s_exit_of(5'h01) |-> $past(ext_int) && !$past(other_int_blocking);
  endproperty
  property p_nmi;
    s_exit_of(5'h02) |-> $past(nmi);
  endproperty
  property p_nmi_vec;
    deliver_nmi |-> deliver_vector == 8'h02 && !exit_req && $past(nmi);
  endproperty
  property p_window;
    s_exit_of(5'h07) |-> $past(interrupt_enable_flag) && !$past(other_int_blocking);
  endproperty
  property p_instr;
    exit_req && exit_cause[4] |-> $past(ev_valid) && exit_cause[3:0] == $past(ev_kind);
  endproperty
  a_entry_guest: assert property (p_entry_guest)
    else $error("guest state missing after entry");
  a_entry_src: assert property (p_entry_src)
    else $error("entry result without request");
  a_exit_guest: assert property (p_exit_guest)
    else $error("exit outside guest or longer than a pulse");
  a_exit_leave: assert property (p_exit_leave)
    else $error("guest not left after exit");
  a_ext: assert property (p_ext)
    else $error("external exit without cause");
  a_nmi: assert property (p_nmi)
    else $error("nmi exit without nmi");
  a_nmi_vec: assert property (p_nmi_vec)
    else $error("nmi delivery wrong");
  a_window: assert property (p_window)
    else $error("window exit while blocked");
  a_instr: assert property (p_instr)
    else $error("instruction exit kind mismatch");
endmodule // vmexd_chk

// ===== verif/testbench.sv
// Self-checking bench for the guest exit decision block, random plus corners.
// Assumes clk_en high throughout; registers reached over AXI4-Lite.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0000_E60B, off = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, ev_kind = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic entry_req = 1'b0, guest_leave = 1'b0, ev_valid = 1'b0, ext_int = 1'b0, nmi = 1'b0;
  logic interrupt_enable_flag = 1'b0, other_int_blocking = 1'b0;
  logic io_bitmap_hit = 1'b0, mr_bitmap_hit = 1'b0;
  logic [63:0] time_stamp_counter = 64'h0, ts_result, tq, cnt, offs;
  logic entry_ok, entry_fail, guest_mode, exit_req, deliver_int, deliver_nmi, int_blocked;
  logic nmi_interrupt_return_instruction_unblock, task_priority_shadow_en, ts_result_valid, xq, dn, di, tv, ib, nu, tp;
  logic [4:0] exit_cause, cq;
  logic [7:0] deliver_vector, dv;
  logic [31:0] d, a, s;
  int miscompares = 0, checks_done = 0, cyc = 0;
  vmexd_top dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected cause; f = {ext, nmi, if, blocking, io hit, model hit}
  function automatic logic [4:0] ecause(logic [31:0] a, s, logic [3:0] k, logic [5:0] f);
    int bt [16] = '{0, 7, 9, 10, 11, 12, 19, 20, 23, 0, 0, 0, 29, 30, 0, 0};
    logic hit;
    // A delivered interrupt wins over any later exit
    if (f[4]) return a[3] ? 5'h02 : 5'h00;
    if (f[5] && !f[2] && (a[0] || f[3])) return a[0] ? 5'h01 : 5'h00;
    if (s[2] && f[3] && !f[2]) return 5'h07;
    hit = s[bt[k]] && bt[k] != 0;
    if (k == 4'h9) hit = s[25] ? f[1] : s[24];
    if (k == 4'hA || k == 4'hB || k == 4'hE) hit = s[28] ? f[0] : 1'b1;
    return hit ? {1'b1, k} : 5'h00;
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // AXI masters: hold each channel until its ready is sampled
  task automatic axw(input logic [7:0] ad, input logic [31:0] wd);
    s_axi_awaddr <= ad;
    s_axi_wdata <= wd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] ad);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic enter(input logic ok);
    entry_req <= 1'b1;
    do @(posedge clk); while (!(entry_ok || entry_fail));
    entry_req <= 1'b0;
    chk("entry_ok", ok, entry_ok);
    chk("entry_fail", !ok, entry_fail);
    @(posedge clk);
    chk("guest_mode", ok, guest_mode);
  endtask
  // One event cycle, outputs captured as settled one cycle later
  task automatic ev(input logic [3:0] k, input logic [5:0] f);
    cnt = {rnd(), rnd()};
    ev_valid <= 1'b1;
    ev_kind <= k;
    time_stamp_counter <= cnt;
    {ext_int, nmi, interrupt_enable_flag, other_int_blocking, io_bitmap_hit, mr_bitmap_hit} <= f;
    @(posedge clk);
    {ev_valid, ext_int, nmi, interrupt_enable_flag, other_int_blocking} <= 5'h00;
    @(posedge clk);
    {xq, cq, dn, di, dv, tq, tv} = {exit_req, exit_cause, deliver_nmi, deliver_int,
                                     deliver_vector, ts_result, ts_result_valid};
    {ib, nu, tp} = {int_blocked, nmi_interrupt_return_instruction_unblock, task_priority_shadow_en};
  endtask
  task automatic leave();
    guest_leave <= 1'b1;
    do @(posedge clk); while (guest_mode);
    guest_leave <= 1'b0;
    @(posedge clk);
  endtask
  task automatic scen(input logic [31:0] a, s, input logic [3:0] k, input logic [5:0] f);
    logic [4:0] e;
    axw(8'h00, a);
    axw(8'h04, s);
    enter(1'b1);
    ev(k, f);
    e = ecause(a, s, k, f);
    chk("exit_req", |e, xq);
    if (|e) chk("exit_cause", e, cq);
    chk("int_blocked", !a[0] && (!f[3] || f[2]), ib);
    chk("nmi_interrupt_return_instruction", !a[3], nu);
    chk("shadow_en", s[21], tp);
    chk("ts_valid", !e && (k == 4'h5 || k == 4'hE), tv);
    if (!e && (k == 4'h5 || k == 4'hE))
      chk("ts_result", cnt + (s[3] ? offs : 64'h0), tq);
    leave();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) if (i != 3 && i != 4) begin
      axr(8'(i * 4));
      chk("reg_reset", i == 5 ? 32'h16 : i == 6 ? 32'h1F : i == 7 ? 32'h0401_E172 :
          i == 8 ? 32'h77FB_FFFE : 32'h0, d);
    end
    axr(8'h40);
    chk("unmapped", {2'b10, 32'h0}, {r, d});
    axw(8'h14, 32'hFFFF_FFFF);
    chk("cap_wr_resp", 2'b10, r);
    enter(1'b0);
    axr(8'h08);
    chk("status_fail", 32'h4, d & 32'h4);
    offs = {rnd(), rnd()};
    axw(8'h0C, offs[31:0]);
    axw(8'h10, offs[63:32]);
    axr(8'h10);
    chk("ts_off_hi", offs[63:32], d);
    // Interrupt corners, exit and delivery alike
    scen(32'h1F, 32'h0401_E172, 4'h0, 6'b100000);
    scen(32'h1F, 32'h0401_E172, 4'h0, 6'b010000);
    scen(32'h16, 32'h0401_E172, 4'h0, 6'b010000);
    chk("nmi_vector", {1'b1, 8'h02}, {dn, dv});
    scen(32'h16, 32'h0401_E172, 4'h0, 6'b101000);
    chk("deliver_int", 1'b1, di);
    // Vectors latched at entry: a write in guest must not take effect
    axw(8'h04, 32'h0401_E1F2);
    enter(1'b1);
    axw(8'h04, 32'h0401_E172);
    ev(4'h1, 6'h00);
    chk("latched", 5'h11, cq);
    leave();
    ev(4'h1, 6'h00);
    chk("outside_guest", 1'b0, xq);
    // Random sweep over every kind and control bit
    repeat (120) begin
      a = 32'h16 | (rnd() & 32'h9);
      s = 32'h0401_E172 | (rnd() & 32'h77FB_FFFE);
      scen(a, s, 4'(rnd() % 14 + 1), {2'b00, 4'(rnd())});
    end
    give_verdict();
  end
endmodule // testbench
bind vmexd_top vmexd_chk u_chk (.*);
